/* pmx_map.vh */
// register map, field layout and reset values of the port function mux
`ifndef PMX_MAP_VH
`define PMX_MAP_VH

// ------------------------------------------------------------
// special function register addresses
// ------------------------------------------------------------
`define PMX_P1_SEL_ADDR 8'h91
`define PMX_P3_SEL_ADDR 8'h93
`define PMX_P4_SEL_ADDR 8'h94

// ------------------------------------------------------------
// implemented bits and reset values
// ------------------------------------------------------------
`define PMX_P1_SEL_MASK 8'hF0
`define PMX_P3_SEL_MASK 8'hC0
`define PMX_P4_SEL_MASK 8'hFB
`define PMX_SEL_RESET 8'h00
`define PMX_BYTE_ZERO 8'h00

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PMX_P1_ADC_HI 7
`define PMX_P1_ADC_LO 4
`define PMX_P3_I2C_HI 7
`define PMX_P3_I2C_LO 6
`define PMX_P4_PWM_HI 7
`define PMX_P4_PWM_LO 3
`define PMX_P4_DDC_HI 1
`define PMX_P4_DDC_LO 0

// ------------------------------------------------------------
// pin cell index ranges within the flat 24-pin vector
// ------------------------------------------------------------
`define PMX_PINS 24
`define PMX_P1_HI 7
`define PMX_P1_LO 0
`define PMX_P3_HI 15
`define PMX_P3_LO 8
`define PMX_P4_HI 23
`define PMX_P4_LO 16

// ------------------------------------------------------------
// fixed peripheral pins and their drive style per port
// ------------------------------------------------------------
`define PMX_P1_T2_CNT 0
`define PMX_P1_T2_EX 1
`define PMX_P1_RXD2 2
`define PMX_P3_RXD 0
`define PMX_P3_INT_HI 3
`define PMX_P3_INT_LO 2
`define PMX_P3_CNT_HI 5
`define PMX_P3_CNT_LO 4
`define PMX_P1_OD 8'h00
`define PMX_P1_DRIVE 8'h08
`define PMX_P3_OD 8'hC0
`define PMX_P3_DRIVE 8'h02
`define PMX_P4_OD 8'h03
`define PMX_P4_DRIVE 8'hF8

// ------------------------------------------------------------
// idle levels of the peripheral inputs
// ------------------------------------------------------------
`define PMX_ADC_IDLE 4'h0
`define PMX_INT_IDLE 2'h3
`define PMX_CNT_IDLE 2'h0

`endif

/* pmx_sfr_reg.v */
// one selection register on the core's special function register bus
`default_nettype none

module pmx_sfr_reg #(
  parameter [7:0] ADDR = 8'h00,
  parameter [7:0] MASK = 8'hFF
) (
  input wire clock_i,
  input wire arst_n_i,
  input wire ce_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_wr_i,
  output reg [7:0] value_o
);

`include "pmx_map.vh"

  // store written byte, reserved bits forced to zero
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      value_o <= `PMX_SEL_RESET;
    end else if (ce_i && sfr_wr_i && (sfr_addr_i == ADDR)) begin
      value_o <= sfr_wdata_i & MASK;
    end
  end

endmodule // pmx_sfr_reg

`default_nettype wire

/* pmx_pin_cell.v */
// output stage of one bidirectional port pin
`default_nettype none

module pmx_pin_cell (
  input wire clock_i,
  input wire arst_n_i,
  input wire ce_i,
  input wire latch_i,
  input wire alt_sel_i,
  input wire alt_od_i,
  input wire alt_data_i,
  input wire alt_drive_i,
  output reg pad_o,
  output reg pad_oe_o
);

  reg next_pad;
  reg next_oe;

  // choose between plain i/o and the alternate driver
  always @* begin
    next_pad = 1'b0;
    next_oe = 1'b0;
    if (alt_sel_i) begin
      if (alt_od_i) begin
        next_oe = ~alt_data_i; // open drain: pull low only
      end else begin
        next_pad = alt_data_i;
        next_oe = alt_drive_i; // input or analog use leaves pin free
      end
    end else begin
      next_oe = ~latch_i; // quasi bidirectional: a one lets the pin be read
    end
  end

  // registered pad drive
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pad_o <= 1'b0;
      pad_oe_o <= 1'b0;
    end else if (ce_i) begin
      pad_o <= next_pad;
      pad_oe_o <= next_oe;
    end
  end

endmodule // pmx_pin_cell

`default_nettype wire

/* pmx_port_mux.v */
// port alternate function mux: selection registers, pin cells, peripheral routing
//
// Notes on behaviour
// [RL1] ports zero and two carry only the external bus, and only in the large package.
// [RL2] every pin of ports one, three and four is bidirectional and acts as plain i/o when its alternate is idle.
// [RL3] a set selection bit routes its pin of ports one, three and four with nothing else needed.
// [RL4] port one uses its selection register, except timer two and uart two pins.
// [RL5] after reset pins 1.4 to 1.7 are plain i/o.
// [RL6] pins 3.6 and 3.7 are plain i/o or two-wire data and clock, strobes elsewhere.
// [RL7] two-wire pins of port three and all port four alternates use their registers.
// [RL8] after reset every selectable pin is plain i/o and switches only on a one.
// [RL9] uart, interrupt and counter pins of port three follow their own peripheral enables.
// [RL10] port one bits 7..4 pick analog channels 3..0 on pins 1.7..1.4, low bits reserved.
// [RL11] port three bit 7 clock and 6 data; port four bits 1,0 display channel, 7..3 pwm.
`default_nettype none

module pmx_port_mux (
  input wire clock_i,
  input wire arst_n_i,
  input wire ce_i,
  // core special function register bus
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  output reg [7:0] sfr_rdata_o,
  output reg sfr_hit_o,
  // package strap: high on the large package
  input wire wide_package_i,
  // port latches from the core
  input wire [7:0] p1_latch_i,
  input wire [7:0] p3_latch_i,
  input wire [7:0] p4_latch_i,
  // pads of ports one, three and four
  input wire [7:0] p1_pad_i,
  output wire [7:0] p1_pad_o,
  output wire [7:0] p1_pad_oe_o,
  input wire [7:0] p3_pad_i,
  output wire [7:0] p3_pad_o,
  output wire [7:0] p3_pad_oe_o,
  input wire [7:0] p4_pad_i,
  output wire [7:0] p4_pad_o,
  output wire [7:0] p4_pad_oe_o,
  // pin levels seen by the core
  output reg [7:0] p1_pin_o,
  output reg [7:0] p3_pin_o,
  output reg [7:0] p4_pin_o,
  // external bus on ports zero and two
  input wire [7:0] xbus_p0_out_i,
  input wire xbus_p0_oe_i,
  input wire [7:0] xbus_p2_out_i,
  output reg [7:0] xbus_data_o,
  input wire [7:0] p0_pad_i,
  output reg [7:0] p0_pad_o,
  output reg [7:0] p0_pad_oe_o,
  output reg [7:0] p2_pad_o,
  output reg [7:0] p2_pad_oe_o,
  // timer two and second uart on port one
  input wire t2_pins_en_i,
  output reg t2_cnt_o,
  output reg t2_ex_o,
  input wire uart2_en_i,
  input wire uart2_txd_i,
  output reg uart2_rxd_o,
  // analog channel enables, channel 3 down to 0
  output reg [3:0] adc_chan_en_o,
  // port three peripherals
  input wire uart_en_i,
  input wire uart_txd_i,
  output reg uart_rxd_o,
  input wire [1:0] int_en_i,
  output reg [1:0] int_n_o,
  input wire [1:0] tmr_cnt_en_i,
  output reg [1:0] tmr_cnt_o,
  input wire i2c_scl_low_i,
  input wire i2c_sda_low_i,
  output reg i2c_scl_o,
  output reg i2c_sda_o,
  // port four peripherals
  input wire ddc_scl_low_i,
  input wire ddc_sda_low_i,
  output reg ddc_scl_o,
  output reg ddc_sda_o,
  input wire [4:0] pwm_i
);

`include "pmx_map.vh"

  // ------------------------------------------------------------
  // selection registers
  // ------------------------------------------------------------

  wire [7:0] port1_function_select;
  wire [7:0] port3_function_select;
  wire [7:0] port4_function_select;

  // reset clears all three, so every register-selected pin starts as plain i/o
  pmx_sfr_reg #(
    .ADDR(`PMX_P1_SEL_ADDR),
    .MASK(`PMX_P1_SEL_MASK) // RL10
  ) u_p1_sel (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i),
    .sfr_wr_i(sfr_wr_i),
    .value_o(port1_function_select)
  ); // RL5 RL8

  pmx_sfr_reg #(
    .ADDR(`PMX_P3_SEL_ADDR),
    .MASK(`PMX_P3_SEL_MASK)
  ) u_p3_sel (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i),
    .sfr_wr_i(sfr_wr_i),
    .value_o(port3_function_select)
  ); // RL7 RL8

  pmx_sfr_reg #(
    .ADDR(`PMX_P4_SEL_ADDR),
    .MASK(`PMX_P4_SEL_MASK)
  ) u_p4_sel (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i),
    .sfr_wr_i(sfr_wr_i),
    .value_o(port4_function_select)
  ); // RL7 RL8

  // ------------------------------------------------------------
  // register read back
  // ------------------------------------------------------------

  // address match, shared by the three read terms
  function addr_hit;
    input [7:0] addr;
    input [7:0] reg_addr;
    begin
      addr_hit = (addr == reg_addr);
    end
  endfunction

  wire rd_p1 = addr_hit(sfr_addr_i, `PMX_P1_SEL_ADDR);
  wire rd_p3 = addr_hit(sfr_addr_i, `PMX_P3_SEL_ADDR);
  wire rd_p4 = addr_hit(sfr_addr_i, `PMX_P4_SEL_ADDR);

  reg [7:0] next_rdata;

  // unmapped addresses read zero with no hit
  always @* begin
    next_rdata = `PMX_BYTE_ZERO;
    if (rd_p1) begin
      next_rdata = port1_function_select;
    end else if (rd_p3) begin
      next_rdata = port3_function_select;
    end else if (rd_p4) begin
      next_rdata = port4_function_select;
    end
  end

  // read data one cycle after the strobe
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sfr_rdata_o <= `PMX_BYTE_ZERO;
      sfr_hit_o <= 1'b0;
    end else if (ce_i) begin
      sfr_hit_o <= sfr_rd_i & (rd_p1 | rd_p3 | rd_p4);
      if (sfr_rd_i) begin
        sfr_rdata_o <= next_rdata;
      end
    end
  end

  // ------------------------------------------------------------
  // alternate requests per pin
  // ------------------------------------------------------------

  wire [7:0] p1_sel;
  wire [7:0] p1_od;
  wire [7:0] p1_data;
  wire [7:0] p1_drive;
  wire [7:0] p3_sel;
  wire [7:0] p3_od;
  wire [7:0] p3_data;
  wire [7:0] p3_drive;
  wire [7:0] p4_sel;
  wire [7:0] p4_od;
  wire [7:0] p4_data;
  wire [7:0] p4_drive;

  // port one: analog from register, timer two and uart two from their own enables
  assign p1_sel = {port1_function_select[`PMX_P1_ADC_HI:`PMX_P1_ADC_LO],
                   uart2_en_i, uart2_en_i, t2_pins_en_i, t2_pins_en_i}; // RL3 RL4 RL10
  assign p1_od = `PMX_P1_OD;
  assign p1_data = {4'h0, uart2_txd_i, 3'h0};
  assign p1_drive = `PMX_P1_DRIVE; // only the uart two transmit pin drives

  // port three: uart, interrupt, counters by own enables; two-wire by register
  assign p3_sel = {port3_function_select[`PMX_P3_I2C_HI:`PMX_P3_I2C_LO],
                   tmr_cnt_en_i, int_en_i, uart_en_i, uart_en_i}; // RL6 RL7 RL9 RL11
  assign p3_od = `PMX_P3_OD;
  assign p3_data = {~i2c_scl_low_i, ~i2c_sda_low_i, 4'h0, uart_txd_i, 1'b0}; // RL11
  assign p3_drive = `PMX_P3_DRIVE; // only the uart transmit pin drives

  // port four: pwm and display channel by register, pin 4.2 plain i/o
  assign p4_sel = {port4_function_select[`PMX_P4_PWM_HI:`PMX_P4_PWM_LO], 1'b0,
                   port4_function_select[`PMX_P4_DDC_HI:`PMX_P4_DDC_LO]}; // RL3 RL7 RL11
  assign p4_od = `PMX_P4_OD;
  assign p4_data = {pwm_i, 1'b0, ~ddc_scl_low_i, ~ddc_sda_low_i}; // RL11
  assign p4_drive = `PMX_P4_DRIVE;

  // flat vectors over all 24 pins
  wire [`PMX_PINS-1:0] all_latch = {p4_latch_i, p3_latch_i, p1_latch_i};
  wire [`PMX_PINS-1:0] all_sel = {p4_sel, p3_sel, p1_sel};
  wire [`PMX_PINS-1:0] all_od = {p4_od, p3_od, p1_od};
  wire [`PMX_PINS-1:0] all_data = {p4_data, p3_data, p1_data};
  wire [`PMX_PINS-1:0] all_drive = {p4_drive, p3_drive, p1_drive};
  wire [`PMX_PINS-1:0] all_pad;
  wire [`PMX_PINS-1:0] all_oe;

  // ------------------------------------------------------------
  // pin cells
  // ------------------------------------------------------------

  // one output stage per pin, plain i/o whenever its select is low
  genvar g;
  generate
    for (g = 0; g < `PMX_PINS; g = g + 1) begin : g_pin
      pmx_pin_cell u_cell (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .ce_i(ce_i),
        .latch_i(all_latch[g]),
        .alt_sel_i(all_sel[g]),
        .alt_od_i(all_od[g]),
        .alt_data_i(all_data[g]),
        .alt_drive_i(all_drive[g]),
        .pad_o(all_pad[g]),
        .pad_oe_o(all_oe[g])
      ); // RL2
    end
  endgenerate

  assign p1_pad_o = all_pad[`PMX_P1_HI:`PMX_P1_LO];
  assign p1_pad_oe_o = all_oe[`PMX_P1_HI:`PMX_P1_LO];
  assign p3_pad_o = all_pad[`PMX_P3_HI:`PMX_P3_LO];
  assign p3_pad_oe_o = all_oe[`PMX_P3_HI:`PMX_P3_LO];
  assign p4_pad_o = all_pad[`PMX_P4_HI:`PMX_P4_LO];
  assign p4_pad_oe_o = all_oe[`PMX_P4_HI:`PMX_P4_LO];

  // ------------------------------------------------------------
  // input routing to core and peripherals
  // ------------------------------------------------------------

  // pins are always readable; peripheral inputs idle when not enabled
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      p1_pin_o <= `PMX_BYTE_ZERO;
      p3_pin_o <= `PMX_BYTE_ZERO;
      p4_pin_o <= `PMX_BYTE_ZERO;
      t2_cnt_o <= 1'b0;
      t2_ex_o <= 1'b0;
      uart2_rxd_o <= 1'b1;
      adc_chan_en_o <= `PMX_ADC_IDLE;
      uart_rxd_o <= 1'b1;
      int_n_o <= `PMX_INT_IDLE;
      tmr_cnt_o <= `PMX_CNT_IDLE;
      i2c_scl_o <= 1'b1;
      i2c_sda_o <= 1'b1;
      ddc_scl_o <= 1'b1;
      ddc_sda_o <= 1'b1;
    end else if (ce_i) begin
      p1_pin_o <= p1_pad_i; // RL2
      p3_pin_o <= p3_pad_i;
      p4_pin_o <= p4_pad_i;
      t2_cnt_o <= t2_pins_en_i & p1_pad_i[`PMX_P1_T2_CNT]; // RL4
      t2_ex_o <= t2_pins_en_i & p1_pad_i[`PMX_P1_T2_EX];
      uart2_rxd_o <= ~uart2_en_i | p1_pad_i[`PMX_P1_RXD2];
      adc_chan_en_o <= port1_function_select[`PMX_P1_ADC_HI:`PMX_P1_ADC_LO]; // RL10
      uart_rxd_o <= ~uart_en_i | p3_pad_i[`PMX_P3_RXD]; // RL9
      int_n_o <= ~int_en_i | p3_pad_i[`PMX_P3_INT_HI:`PMX_P3_INT_LO];
      tmr_cnt_o <= tmr_cnt_en_i & p3_pad_i[`PMX_P3_CNT_HI:`PMX_P3_CNT_LO];
      i2c_scl_o <= ~port3_function_select[`PMX_P3_I2C_HI] | p3_pad_i[`PMX_P3_I2C_HI]; // RL6
      i2c_sda_o <= ~port3_function_select[`PMX_P3_I2C_LO] | p3_pad_i[`PMX_P3_I2C_LO];
      ddc_scl_o <= ~port4_function_select[`PMX_P4_DDC_HI] | p4_pad_i[`PMX_P4_DDC_HI];
      ddc_sda_o <= ~port4_function_select[`PMX_P4_DDC_LO] | p4_pad_i[`PMX_P4_DDC_LO];
    end
  end

  // ------------------------------------------------------------
  // external bus ports
  // ------------------------------------------------------------

  // ports zero and two serve only the bus and stay dark on the small package
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      p0_pad_o <= `PMX_BYTE_ZERO;
      p0_pad_oe_o <= `PMX_BYTE_ZERO;
      p2_pad_o <= `PMX_BYTE_ZERO;
      p2_pad_oe_o <= `PMX_BYTE_ZERO;
      xbus_data_o <= `PMX_BYTE_ZERO;
    end else if (ce_i) begin
      p0_pad_o <= wide_package_i ? xbus_p0_out_i : `PMX_BYTE_ZERO; // RL1
      p0_pad_oe_o <= {8{wide_package_i & xbus_p0_oe_i}};
      p2_pad_o <= wide_package_i ? xbus_p2_out_i : `PMX_BYTE_ZERO;
      p2_pad_oe_o <= {8{wide_package_i}};
      xbus_data_o <= wide_package_i ? p0_pad_i : `PMX_BYTE_ZERO;
    end
  end

endmodule // pmx_port_mux

`default_nettype wire

/* pmx_port_mux_unused_guard.v */
// no logic of its own: only keeps the implicit net setting paired
`default_nettype none
`default_nettype wire

/* pmx_port_mux_properties.sv */
// concurrent checks on the top ports of the port function mux
`default_nettype none
module pmx_port_mux_properties (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic sfr_hit_o,
  input wire logic wide_package_i,
  input wire logic [7:0] p2_pad_oe_o,
  input wire logic [7:0] p3_pad_o,
  input wire logic [7:0] p3_pad_oe_o,
  input wire logic [7:0] p4_latch_i,
  input wire logic [7:0] p4_pad_o,
  input wire logic [7:0] p4_pad_oe_o,
  input wire logic [3:0] adc_chan_en_o,
  input wire logic uart_en_i,
  input wire logic uart_txd_i,
  input wire logic i2c_sda_low_i,
  input wire logic i2c_scl_o,
  input wire logic [4:0] pwm_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh1, sh3, sh4;
  logic [1:0] age;
  wire is_sel = sfr_addr_i inside {8'h91, 8'h93, 8'h94};
  wire [7:0] rd_exp = (sfr_addr_i == 8'h91) ? sh1 : (sfr_addr_i == 8'h93) ? sh3 : sh4;
  // ------------------------------------------------------------
  // shadow selects and clock-enabled cycles since last write
  // ------------------------------------------------------------
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sh1 <= 8'h00;
      sh3 <= 8'h00;
      sh4 <= 8'h00;
      age <= 2'h3;
    end else if (ce_i) begin
      if (sfr_wr_i && sfr_addr_i == 8'h91) sh1 <= sfr_wdata_i & 8'hF0;
      if (sfr_wr_i && sfr_addr_i == 8'h93) sh3 <= sfr_wdata_i & 8'hC0;
      if (sfr_wr_i && sfr_addr_i == 8'h94) sh4 <= sfr_wdata_i & 8'hFB;
      if (sfr_wr_i && is_sel) age <= 2'h0;
      else if (age != 2'h3) age <= age + 2'h1;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  narrow_pads_a: assert property (ce_i && !wide_package_i |=> p2_pad_oe_o == 8'h00)
    else $error("outer bus pads driven on small package");
  read_back_a: assert property (
    ce_i && sfr_rd_i && is_sel |=> sfr_hit_o && sfr_rdata_o == $past(rd_exp))
    else $error("select readback wrong");
  read_refuse_a: assert property (
    ce_i && sfr_rd_i && !is_sel |=> !sfr_hit_o && sfr_rdata_o == 8'h00)
    else $error("unmapped read answered");
  adc_select_a: assert property (age[1] |-> adc_chan_en_o == sh1[7:4])
    else $error("analog enables differ from select");
  scl_default_a: assert property (age[1] && !sh3[7] |-> i2c_scl_o)
    else $error("clock line seen while unselected");
  gpio_drive_a: assert property (ce_i |=> p4_pad_oe_o[2] != $past(p4_latch_i[2]))
    else $error("plain pin drive wrong");
  uart_pins_a: assert property (
    ce_i && uart_en_i |=> p3_pad_oe_o[1:0] == 2'b10 && p3_pad_o[1] == $past(uart_txd_i))
    else $error("serial pins wrong");
  i2c_drain_a: assert property (
    ce_i && age[1] && sh3[6] |=> !p3_pad_o[6] && p3_pad_oe_o[6] == $past(i2c_sda_low_i))
    else $error("data line not open drain");
  pwm_select_a: assert property (
    ce_i && age[1] && sh4[7] |=> p4_pad_oe_o[7] && p4_pad_o[7] == $past(pwm_i[4]))
    else $error("pwm pin wrong");
endmodule // pmx_port_mux_properties

bind pmx_port_mux pmx_port_mux_properties i_props (.*);
`default_nettype wire

/* pmx_pin_model.sv */
// package pins: pull-ups and outside parties holding lines low
`default_nettype none
module pmx_pin_model #(
  parameter int SETTLE_NS = 0
) (
  input wire logic [7:0] drive_i,
  input wire logic [7:0] drive_en_i,
  input wire logic [7:0] ext_low_i,
  output logic [7:0] level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // driven pins follow the cell, released pins rest on the pull-up
  assign #(SETTLE_NS) level_o = (drive_en_i & drive_i) | (~drive_en_i & ~ext_low_i);
endmodule // pmx_pin_model
`default_nettype wire

/* pmx_port_mux_bench.sv */
// self-checking bench of the port function mux
`default_nettype none
module pmx_port_mux_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0, arst_n_i = 1'b0, ce_i = 1'b1, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0;
  logic wide_package_i = 1'b0, xbus_p0_oe_i = 1'b0, t2_pins_en_i = 1'b0, uart2_en_i = 1'b0;
  logic uart2_txd_i = 1'b1, uart_en_i = 1'b0, uart_txd_i = 1'b1, i2c_scl_low_i = 1'b0;
  logic i2c_sda_low_i = 1'b0, ddc_scl_low_i = 1'b0, ddc_sda_low_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, p0_pad_i = 8'h00;
  logic [7:0] p1_latch_i = 8'hFF, p3_latch_i = 8'hFF, p4_latch_i = 8'hFF;
  logic [7:0] xbus_p0_out_i = 8'h00, xbus_p2_out_i = 8'h00, x1 = 8'h00, x3 = 8'h00, x4 = 8'h00;
  logic [1:0] int_en_i = 2'b00, tmr_cnt_en_i = 2'b00;
  logic [4:0] pwm_i = 5'h00;
  logic [31:0] r;
  logic [7:0] lv3;
  logic [3:0] ex_in;
  logic [7:0] adr [3] = '{8'h91, 8'h93, 8'h94};
  logic [7:0] msk [3] = '{8'hF0, 8'hC0, 8'hFB};
  wire [7:0] p1_pad_i, p3_pad_i, p4_pad_i, p1_pad_o, p3_pad_o, p4_pad_o, sfr_rdata_o;
  wire [7:0] p1_pad_oe_o, p3_pad_oe_o, p4_pad_oe_o, p1_pin_o, p3_pin_o, p4_pin_o;
  wire [7:0] xbus_data_o, p0_pad_o, p0_pad_oe_o, p2_pad_o, p2_pad_oe_o;
  wire [3:0] adc_chan_en_o;
  wire [1:0] int_n_o, tmr_cnt_o;
  wire sfr_hit_o, t2_cnt_o, t2_ex_o, uart2_rxd_o, uart_rxd_o, i2c_scl_o, i2c_sda_o;
  wire ddc_scl_o, ddc_sda_o;
  int error_cnt = 0, checks = 0, seed = 19564, i;
  pmx_port_mux i_dut (.*);
  pmx_pin_model i_pins1 (.drive_i(p1_pad_o), .drive_en_i(p1_pad_oe_o), .ext_low_i(x1),
    .level_o(p1_pad_i));
  pmx_pin_model #(.SETTLE_NS(5)) i_pins3 (.drive_i(p3_pad_o), .drive_en_i(p3_pad_oe_o),
    .ext_low_i(x3), .level_o(p3_pad_i));
  pmx_pin_model i_pins4 (.drive_i(p4_pad_o), .drive_en_i(p4_pad_oe_o), .ext_low_i(x4),
    .level_o(p4_pad_i));
  always #20 clock_i = ~clock_i;
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    tick(1);
    sfr_wr_i = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, exp, input logic hit);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    tick(1);
    check("read", {sfr_rdata_o, 7'h00, sfr_hit_o}, {exp, 7'h00, hit});
    sfr_rd_i = 1'b0;
    tick(1);
  endtask
  // plain pin level: a zero latch drives low, a one leaves the pull-up unless held low
  function automatic logic [7:0] plain_level(input logic [7:0] latch, ext_low);
    return latch & ~ext_low;
  endfunction
  task automatic end_of_test();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog: the sequence needs some 200 cycles, allow fifteen times that
  initial begin
    #120000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge clock_i);
    #1;
    arst_n_i = 1'b1;
    for (i = 0; i < 3; i++) rd(adr[i], 8'h00, 1'b1);
    check("reset pins", {4'h0, adc_chan_en_o, p1_pad_oe_o}, 16'h0000);
    check("scl idle", 16'(i2c_scl_o), 16'h0001);
    rd(8'h92, 8'h00, 1'b0);
    ce_i = 1'b0;
    wr(8'h91, 8'hF0);
    ce_i = 1'b1;
    rd(8'h91, 8'h00, 1'b1);
    for (i = 0; i < 12; i++) begin
      r = $random(seed);
      wr(adr[i % 3], r[7:0]);
      rd(adr[i % 3], r[7:0] & msk[i % 3], 1'b1);
    end
    // one or more alternates of each kind in use at once
    p1_latch_i = 8'h00;
    wide_package_i = 1'b1;
    {t2_pins_en_i, uart2_en_i, uart2_txd_i, uart_en_i, uart_txd_i} = 5'b11010;
    {i2c_sda_low_i, ddc_scl_low_i, pwm_i, int_en_i, tmr_cnt_en_i} = 11'b11_11000_01_10;
    x1 = 8'h02;
    x3 = 8'h85;
    xbus_p2_out_i = 8'h3C;
    wr(8'h91, 8'hA0);
    wr(8'h93, 8'hC0);
    wr(8'h94, 8'hC3);
    tick(3);
    check("p1 oe", {p1_pad_oe_o, 5'h00, t2_cnt_o, t2_ex_o, uart2_rxd_o}, 16'h5805);
    check("adc", 16'(adc_chan_en_o), 16'h000A);
    check("p3 oe", {p3_pad_oe_o, p3_pad_o & p3_pad_oe_o}, 16'h4200);
    check("p3 in", 16'({uart_rxd_o, int_n_o, tmr_cnt_o, i2c_scl_o, i2c_sda_o}), 16'h0028);
    check("p4", {p4_pad_oe_o, p4_pad_o & p4_pad_oe_o}, 16'hC2C0);
    check("ddc", 16'({ddc_scl_o, ddc_sda_o}), 16'h0001);
    check("wide", {p2_pad_oe_o, p2_pad_o}, 16'hFF3C);
    wr(8'h93, 8'h3F);
    tick(2);
    check("i2c off", 16'({p3_pad_oe_o[7:6], i2c_scl_o, i2c_sda_o}), 16'h0003);
    wide_package_i = 1'b0;
    tick(2);
    check("narrow", {p0_pad_oe_o | p2_pad_oe_o, xbus_data_o}, 16'h0000);
    // plain pins under random traffic
    wr(8'h91, 8'h00);
    wr(8'h94, 8'h00);
    {t2_pins_en_i, uart2_en_i, uart_en_i, i2c_sda_low_i, ddc_scl_low_i} = 5'b00000;
    wide_package_i = 1'b1;
    for (i = 0; i < 40; i++) begin
      r = $random(seed);
      {p1_latch_i, p3_latch_i, p4_latch_i} = r[23:0];
      r = $random(seed);
      {x1, x3, x4} = r[23:0];
      r = $random(seed);
      {xbus_p2_out_i, p0_pad_i} = r[15:0];
      xbus_p0_out_i = ~r[7:0];
      xbus_p0_oe_i = r[28];
      {pwm_i, int_en_i, tmr_cnt_en_i, ddc_sda_low_i, i2c_scl_low_i, uart_txd_i} = r[27:16];
      tick(3);
      check("p4 gpio", {p4_pad_oe_o, p4_pin_o}, {~p4_latch_i, p4_latch_i & ~x4});
      check("p1 p3 gpio", {p1_pad_oe_o, p3_pad_oe_o & 8'hC3}, ~{p1_latch_i, p3_latch_i | 8'h3C});
      check("xbus", {p2_pad_o, xbus_data_o}, {xbus_p2_out_i, p0_pad_i});
      check("p0 bus", {p0_pad_oe_o, p0_pad_o}, {{8{xbus_p0_oe_i}}, xbus_p0_out_i});
      check("p1 pins", {p1_pad_o, p1_pin_o}, {8'h00, plain_level(p1_latch_i, x1)});
      lv3 = plain_level(p3_latch_i | {2'b00, tmr_cnt_en_i, int_en_i, 2'b00}, x3);
      ex_in = {~int_en_i | lv3[3:2], tmr_cnt_en_i & lv3[5:4]};
      check("p3 pins", {p3_pad_o, p3_pin_o}, {8'h00, lv3});
      check("p3 in", 16'({int_n_o, tmr_cnt_o}), 16'(ex_in));
    end
    end_of_test();
  end
endmodule // pmx_port_mux_bench
`default_nettype wire
